/* rtl/usbie_pkg.sv */
// usbie_pkg: register map, field positions and reset values of the
// interrupt enable block of a full-speed usb device controller.
// assumes: 16-bit cpu register bus with byte addresses, six endpoints.
package usbie_pkg;

    // ------------------------------------------------------------
    // register geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_EP = 6;
    localparam int NUM_SRC = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] IRQ_SOURCE_ENABLE_OFS = 8'h10;
    localparam logic [7:0] ENDPOINT_READY_IRQ_MASK_OFS = 8'h12;
    localparam logic [7:0] ENDPOINT_NOTREADY_IRQ_MASK_OFS = 8'h14;
    localparam logic [7:0] ENDPOINT_EMPTY_IRQ_MASK_OFS = 8'h16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] IRQ_SOURCE_ENABLE_RST = 16'h0000;
    localparam logic [5:0] ENDPOINT_MASK_RST = 6'h00;

    // ------------------------------------------------------------
    // irq_source_enable field positions
    // ------------------------------------------------------------
    localparam int SUPPLY_CHANGE_IRQ_EN_BIT = 15;
    localparam int WAKEUP_IRQ_EN_BIT = 14;
    localparam int FRAME_START_IRQ_EN_BIT = 13;
    localparam int DEVICE_STATE_IRQ_EN_BIT = 12;
    localparam int CONTROL_STAGE_IRQ_EN_BIT = 11;
    localparam int BUFFER_DRAINED_IRQ_EN_BIT = 10;
    localparam int BUFFER_UNREADY_IRQ_EN_BIT = 9;
    localparam int BUFFER_AVAILABLE_IRQ_EN_BIT = 8;
    localparam int BUS_RESET_FACTOR_BIT = 7;
    localparam int ADDRESS_SET_FACTOR_BIT = 6;
    localparam int CONFIGURATION_SET_FACTOR_BIT = 5;
    localparam int BUS_IDLE_SLEEP_FACTOR_BIT = 4;
    localparam int WRITE_STATUS_STAGE_FACTOR_BIT = 3;
    localparam int READ_STATUS_STAGE_FACTOR_BIT = 2;
    localparam int CONTROL_DONE_FACTOR_BIT = 1;
    localparam int CONTROL_SEQUENCE_FAULT_FACTOR_BIT = 0;

    // lowest bit of the eight source enables
    localparam int SOURCE_EN_LSB = 8;

endpackage

/* rtl/usbie_ep_gate.sv */
// usbie_ep_gate: combines per-endpoint status flags with per-endpoint
// masks and one source enable into a single request.
// assumes: flags are levels held by the status logic outside.
`timescale 1ns/1ps
`default_nettype none

module usbie_ep_gate #(
    parameter int NUM_EP = 6
) (
    input wire logic [NUM_EP-1:0] ep_flag_in,
    input wire logic [NUM_EP-1:0] ep_mask_in,
    input wire logic source_en_in,
    output logic hit_out
);

    // ------------------------------------------------------------
    // per-endpoint qualification
    // ------------------------------------------------------------
    logic [NUM_EP-1:0] ep_hit;

    // endpoint n counts only when its own mask bit is set
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EP; gi++)
        begin : g_ep
            assign ep_hit[gi] = ep_flag_in[gi] & ep_mask_in[gi];
        end
    endgenerate

    // the source enable gates all endpoints together
    assign hit_out = source_en_in & (|ep_hit);

endmodule
`default_nettype wire

/* rtl/usbie_top.sv */
// usbie_top: interrupt enable registers of a full-speed usb device
// controller, their factor gating and the interrupt request output.
// assumes: cpu bus pins synchronous to ref_clk_in; status flags and
// factor pulses come from the device control unit outside this block.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bits 15..8 enable the eight sources
// - bit 7 lets bus reset set state flag
// - bit 6 lets set address set flag
// - bit 5 lets set configuration set flag
// - bit 4 lets suspend set state flag
// - bit 3 gates write status-stage entry
// - bit 2 gates read status-stage entry
// - bit 1 gates control transfer completion
// - bit 0 gates control sequence error
// - second register: per-endpoint ready masks
// - third register: per-endpoint not-ready masks
// - fourth register: per-endpoint empty masks
// - setup end always sets stage flag
module usbie_top #(
    parameter int NUM_EP = usbie_pkg::NUM_EP
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic soft_rst_in,
    // cpu register bus
    input wire logic cpu_cs_n_in,
    input wire logic cpu_rd_n_in,
    input wire logic cpu_wr_n_in,
    input wire logic [usbie_pkg::ADDR_W-1:0] cpu_addr_in,
    input wire logic [usbie_pkg::DATA_W-1:0] cpu_data_in,
    output logic [usbie_pkg::DATA_W-1:0] cpu_data_out,
    output logic cpu_data_oe_n_out,
    // device-state factors, one-cycle pulses
    input wire logic bus_reset_factor_in,
    input wire logic address_set_factor_in,
    input wire logic configuration_set_factor_in,
    input wire logic bus_idle_sleep_factor_in,
    // control-stage factors, one-cycle pulses
    input wire logic setup_end_factor_in,
    input wire logic write_status_stage_factor_in,
    input wire logic read_status_stage_factor_in,
    input wire logic control_done_factor_in,
    input wire logic control_sequence_fault_factor_in,
    // status flags held outside
    input wire logic supply_change_flag_in,
    input wire logic wakeup_flag_in,
    input wire logic frame_start_flag_in,
    input wire logic device_state_changed_flag_in,
    input wire logic control_stage_changed_flag_in,
    input wire logic [NUM_EP-1:0] ep_drained_flag_in,
    input wire logic [NUM_EP-1:0] ep_unready_flag_in,
    input wire logic [NUM_EP-1:0] ep_available_flag_in,
    // results
    output logic device_state_flag_set_out,
    output logic control_stage_flag_set_out,
    output logic wakeup_irq_en_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // asynchronous assertion, release after two clock edges
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic bus_wr;
    logic bus_rd;
    logic sel_src;
    logic sel_ready;
    logic sel_notready;
    logic sel_empty;

    // a write lands on every cycle the strobe is low; rewriting is harmless
    assign bus_wr = ~cpu_cs_n_in & ~cpu_wr_n_in;
    assign bus_rd = ~cpu_cs_n_in & ~cpu_rd_n_in;

    // address match per register
    assign sel_src = cpu_addr_in == usbie_pkg::IRQ_SOURCE_ENABLE_OFS;
    assign sel_ready = cpu_addr_in == usbie_pkg::ENDPOINT_READY_IRQ_MASK_OFS;
    assign sel_notready = cpu_addr_in == usbie_pkg::ENDPOINT_NOTREADY_IRQ_MASK_OFS;
    assign sel_empty = cpu_addr_in == usbie_pkg::ENDPOINT_EMPTY_IRQ_MASK_OFS;

    // ------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------
    logic [15:0] irq_source_enable_q;
    logic [NUM_EP-1:0] endpoint_available_mask_q;
    logic [NUM_EP-1:0] endpoint_unready_mask_q;
    logic [NUM_EP-1:0] endpoint_drained_mask_q;

    // source enables and factor masks; bus reset has no path here
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_source_enable_q <= usbie_pkg::IRQ_SOURCE_ENABLE_RST;
        end
        else if (soft_rst_in)
        begin
            irq_source_enable_q <= usbie_pkg::IRQ_SOURCE_ENABLE_RST;
        end
        else if (bus_wr && sel_src)
        begin
            irq_source_enable_q <= cpu_data_in;
        end
    end

    // endpoint ready masks, only the low field is stored
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            endpoint_available_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (soft_rst_in)
        begin
            endpoint_available_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (bus_wr && sel_ready)
        begin
            endpoint_available_mask_q <= cpu_data_in[NUM_EP-1:0];
        end
    end

    // endpoint not-ready masks
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            endpoint_unready_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (soft_rst_in)
        begin
            endpoint_unready_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (bus_wr && sel_notready)
        begin
            endpoint_unready_mask_q <= cpu_data_in[NUM_EP-1:0];
        end
    end

    // endpoint empty / size-error masks
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            endpoint_drained_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (soft_rst_in)
        begin
            endpoint_drained_mask_q <= NUM_EP'(usbie_pkg::ENDPOINT_MASK_RST);
        end
        else if (bus_wr && sel_empty)
        begin
            endpoint_drained_mask_q <= cpu_data_in[NUM_EP-1:0];
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic [15:0] rd_data_d;
    logic [15:0] rd_data_q;

    // unmapped addresses and reserved bits return zero
    always_comb
    begin
        rd_data_d = 16'h0000;
        if (sel_src)
        begin
            rd_data_d = irq_source_enable_q;
        end
        else if (sel_ready)
        begin
            rd_data_d[NUM_EP-1:0] = endpoint_available_mask_q;
        end
        else if (sel_notready)
        begin
            rd_data_d[NUM_EP-1:0] = endpoint_unready_mask_q;
        end
        else if (sel_empty)
        begin
            rd_data_d[NUM_EP-1:0] = endpoint_drained_mask_q;
        end
    end

    // read data is captured while the read strobe is low
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= 16'h0000;
        end
        else if (bus_rd)
        begin
            rd_data_q <= rd_data_d;
        end
    end

    assign cpu_data_out = rd_data_q;
    // driver enable is low while a read is selected
    assign cpu_data_oe_n_out = ~bus_rd;

    // ------------------------------------------------------------
    // factor gating
    // ------------------------------------------------------------
    logic dev_state_set_d;
    logic ctrl_stage_set_d;
    logic dev_state_set_q;
    logic ctrl_stage_set_q;

    // four device-state factors, each behind its own bit
    assign dev_state_set_d =
        (bus_reset_factor_in & irq_source_enable_q[usbie_pkg::BUS_RESET_FACTOR_BIT])
        | (address_set_factor_in & irq_source_enable_q[usbie_pkg::ADDRESS_SET_FACTOR_BIT])
        | (configuration_set_factor_in
           & irq_source_enable_q[usbie_pkg::CONFIGURATION_SET_FACTOR_BIT])
        | (bus_idle_sleep_factor_in & irq_source_enable_q[usbie_pkg::BUS_IDLE_SLEEP_FACTOR_BIT]);

    // setup end has no mask bit and always passes
    assign ctrl_stage_set_d =
        setup_end_factor_in
        | (write_status_stage_factor_in
           & irq_source_enable_q[usbie_pkg::WRITE_STATUS_STAGE_FACTOR_BIT])
        | (read_status_stage_factor_in
           & irq_source_enable_q[usbie_pkg::READ_STATUS_STAGE_FACTOR_BIT])
        | (control_done_factor_in & irq_source_enable_q[usbie_pkg::CONTROL_DONE_FACTOR_BIT])
        | (control_sequence_fault_factor_in
           & irq_source_enable_q[usbie_pkg::CONTROL_SEQUENCE_FAULT_FACTOR_BIT]);

    // flag set requests leave one cycle after the factor
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_state_set_q <= 1'b0;
            ctrl_stage_set_q <= 1'b0;
        end
        else
        begin
            dev_state_set_q <= dev_state_set_d;
            ctrl_stage_set_q <= ctrl_stage_set_d;
        end
    end

    assign device_state_flag_set_out = dev_state_set_q;
    assign control_stage_flag_set_out = ctrl_stage_set_q;
    assign wakeup_irq_en_out = irq_source_enable_q[usbie_pkg::WAKEUP_IRQ_EN_BIT];

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    logic [usbie_pkg::NUM_SRC-1:0] src_flag;
    logic [usbie_pkg::NUM_SRC-1:0] src_en;
    logic [usbie_pkg::NUM_SRC-1:0] src_hit;
    logic drained_hit;
    logic unready_hit;
    logic available_hit;
    logic irq_q;

    // endpoint sources: source enable and that endpoint's mask both needed
    usbie_ep_gate #(
        .NUM_EP(NUM_EP)
    ) u_drained_gate (
        .ep_flag_in(ep_drained_flag_in),
        .ep_mask_in(endpoint_drained_mask_q),
        .source_en_in(irq_source_enable_q[usbie_pkg::BUFFER_DRAINED_IRQ_EN_BIT]),
        .hit_out(drained_hit)
    );

    usbie_ep_gate #(
        .NUM_EP(NUM_EP)
    ) u_unready_gate (
        .ep_flag_in(ep_unready_flag_in),
        .ep_mask_in(endpoint_unready_mask_q),
        .source_en_in(irq_source_enable_q[usbie_pkg::BUFFER_UNREADY_IRQ_EN_BIT]),
        .hit_out(unready_hit)
    );

    usbie_ep_gate #(
        .NUM_EP(NUM_EP)
    ) u_available_gate (
        .ep_flag_in(ep_available_flag_in),
        .ep_mask_in(endpoint_available_mask_q),
        .source_en_in(irq_source_enable_q[usbie_pkg::BUFFER_AVAILABLE_IRQ_EN_BIT]),
        .hit_out(available_hit)
    );

    // source flags in enable-bit order, bit 7 is the supply change source
    assign src_flag = {supply_change_flag_in, wakeup_flag_in, frame_start_flag_in,
                       device_state_changed_flag_in, control_stage_changed_flag_in,
                       drained_hit, unready_hit, available_hit};
    assign src_en = irq_source_enable_q[usbie_pkg::SOURCE_EN_LSB +: usbie_pkg::NUM_SRC];

    // each source passes only with its own enable bit
    genvar gs;
    generate
        for (gs = 0; gs < usbie_pkg::NUM_SRC; gs++)
        begin : g_src
            assign src_hit[gs] = src_flag[gs] & src_en[gs];
        end
    endgenerate

    // request is a registered level, high while any enabled flag stands
    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |src_hit;
        end
    end

    assign irq_out = irq_q;

endmodule
`default_nettype wire

/* testbench/usbie_monitor.sv */
// usbie_monitor: timing checks on the ports of usbie_top.
// assumes: bound to usbie_top; shadows the enables from bus writes.
`timescale 1ns/1ps
`default_nettype none

module usbie_monitor #(
    parameter int NUM_EP = 6
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic soft_rst_in,
    input wire logic cpu_cs_n_in,
    input wire logic cpu_rd_n_in,
    input wire logic cpu_wr_n_in,
    input wire logic [7:0] cpu_addr_in,
    input wire logic [15:0] cpu_data_in,
    input wire logic [15:0] cpu_data_out,
    input wire logic cpu_data_oe_n_out,
    input wire logic bus_reset_factor_in,
    input wire logic address_set_factor_in,
    input wire logic configuration_set_factor_in,
    input wire logic bus_idle_sleep_factor_in,
    input wire logic setup_end_factor_in,
    input wire logic write_status_stage_factor_in,
    input wire logic read_status_stage_factor_in,
    input wire logic control_done_factor_in,
    input wire logic control_sequence_fault_factor_in,
    input wire logic supply_change_flag_in,
    input wire logic wakeup_flag_in,
    input wire logic frame_start_flag_in,
    input wire logic device_state_changed_flag_in,
    input wire logic control_stage_changed_flag_in,
    input wire logic [NUM_EP-1:0] ep_drained_flag_in,
    input wire logic [NUM_EP-1:0] ep_unready_flag_in,
    input wire logic [NUM_EP-1:0] ep_available_flag_in,
    input wire logic device_state_flag_set_out,
    input wire logic control_stage_flag_set_out,
    input wire logic wakeup_irq_en_out,
    input wire logic irq_out
);
    logic [15:0] src_q;
    logic [NUM_EP-1:0] avl_q, unr_q, drn_q;
    logic [15:0] exp_rd;
    logic rd_hit, st_cond, cs_cond, irq_cond;
    assign rd_hit = !cpu_cs_n_in && !cpu_rd_n_in;
    assign st_cond = |({bus_reset_factor_in, address_set_factor_in, configuration_set_factor_in,
        bus_idle_sleep_factor_in} & src_q[7:4]);
    assign cs_cond = setup_end_factor_in | |({write_status_stage_factor_in, read_status_stage_factor_in,
        control_done_factor_in, control_sequence_fault_factor_in} & src_q[3:0]);
    assign irq_cond = |({supply_change_flag_in, wakeup_flag_in, frame_start_flag_in, device_state_changed_flag_in,
        control_stage_changed_flag_in, |(ep_drained_flag_in & drn_q), |(ep_unready_flag_in & unr_q),
        |(ep_available_flag_in & avl_q)} & src_q[15:8]);

    // shadow copy of the four enable registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in || soft_rst_in)
        begin
            src_q <= 16'h0000;
            avl_q <= '0;
            unr_q <= '0;
            drn_q <= '0;
        end
        else if (!cpu_cs_n_in && !cpu_wr_n_in)
        begin
            case (cpu_addr_in)
                usbie_pkg::IRQ_SOURCE_ENABLE_OFS: src_q <= cpu_data_in;
                usbie_pkg::ENDPOINT_READY_IRQ_MASK_OFS: avl_q <= cpu_data_in[NUM_EP-1:0];
                usbie_pkg::ENDPOINT_NOTREADY_IRQ_MASK_OFS: unr_q <= cpu_data_in[NUM_EP-1:0];
                usbie_pkg::ENDPOINT_EMPTY_IRQ_MASK_OFS: drn_q <= cpu_data_in[NUM_EP-1:0];
                default: ;
            endcase
        end
    end

    // read value expected for the address on the bus
    always_comb
    begin
        case (cpu_addr_in)
            usbie_pkg::IRQ_SOURCE_ENABLE_OFS: exp_rd = src_q;
            usbie_pkg::ENDPOINT_READY_IRQ_MASK_OFS: exp_rd = 16'(avl_q);
            usbie_pkg::ENDPOINT_NOTREADY_IRQ_MASK_OFS: exp_rd = 16'(unr_q);
            usbie_pkg::ENDPOINT_EMPTY_IRQ_MASK_OFS: exp_rd = 16'(drn_q);
            default: exp_rd = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    dev_state_set_a: assert property (device_state_flag_set_out == $past(st_cond))
        else $error("device state set pulse wrong");
    stage_set_a: assert property (cs_cond |=> control_stage_flag_set_out)
        else $error("control stage set pulse missing");
    setup_end_a: assert property (setup_end_factor_in |=> control_stage_flag_set_out)
        else $error("setup end did not set stage flag");
    stage_quiet_a: assert property (!cs_cond |=> !control_stage_flag_set_out)
        else $error("stage set pulse without enabled factor");
    irq_level_a: assert property (irq_out == $past(irq_cond))
        else $error("irq level wrong");
    read_data_a: assert property (rd_hit |=> cpu_data_out == $past(exp_rd))
        else $error("read data wrong");
    read_hold_a: assert property (!rd_hit |=> $stable(cpu_data_out))
        else $error("read data changed without read");
    oe_drive_a: assert property (cpu_data_oe_n_out == !rd_hit)
        else $error("data drive enable wrong");
    wakeup_en_a: assert property (wakeup_irq_en_out == src_q[14])
        else $error("wakeup enable output wrong");
    soft_clear_a: assert property (soft_rst_in |=> !wakeup_irq_en_out)
        else $error("software reset left enable set");

    state_cov: cover property (device_state_flag_set_out);
    stage_cov: cover property (control_stage_flag_set_out);
    irq_cov: cover property ($fell(irq_out));
endmodule
`default_nettype wire

/* testbench/usbie_cpu_model.sv */
// usbie_cpu_model: host cpu on the 16-bit register bus.
// assumes: tasks are entered 1 ns after a rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none

module usbie_cpu_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [7:0] addr_out,
    output logic [15:0] data_out
);
    initial
    begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 8'h00;
        data_out = 16'h0000;
    end

    // one write cycle, then one idle edge so strobes never glitch between calls;
    // released lines show the inverse of the last value
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        cs_n_out = 1'b0;
        wr_n_out = 1'b0;
        addr_out = a;
        data_out = d;
        @(posedge clk_in);
        #1;
        cs_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = ~a;
        data_out = ~d;
        @(posedge clk_in);
        #1;
    endtask

    // one read cycle, then one idle edge; data taken after the capturing edge
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        cs_n_out = 1'b0;
        rd_n_out = 1'b0;
        addr_out = a;
        @(posedge clk_in);
        #1;
        d = rdata_in;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        addr_out = ~a;
        @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// tb_top: register, factor gating and irq tests of usbie_top.
// assumes: inputs change 1 ns after rising edges of an 8 ns clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int NUM_EP = 6;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic soft_rst = 1'b0;
    logic cs_n, rd_n, wr_n, oe_n, st_set, cs_set, wk_en, irq;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [8:0] fac = 9'h000; // setup end, four state, four stage factors
    logic [4:0] flg = 5'h00; // supply, wakeup, frame, state, stage flags
    logic [NUM_EP-1:0] drn = '0;
    logic [NUM_EP-1:0] unr = '0;
    logic [NUM_EP-1:0] avl = '0;
    int err_total = 0;
    int num_checks = 0;
    logic [7:0] regs [4] = '{8'h10, 8'h12, 8'h14, 8'h16};

    always #4 ref_clk_in = ~ref_clk_in;

    usbie_cpu_model u_cpu (.clk_in(ref_clk_in), .rdata_in(rdata), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata));

    usbie_top #(.NUM_EP(NUM_EP)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .soft_rst_in(soft_rst),
        .cpu_cs_n_in(cs_n), .cpu_rd_n_in(rd_n), .cpu_wr_n_in(wr_n), .cpu_addr_in(addr), .cpu_data_in(wdata),
        .cpu_data_out(rdata), .cpu_data_oe_n_out(oe_n), .bus_reset_factor_in(fac[7]),
        .address_set_factor_in(fac[6]), .configuration_set_factor_in(fac[5]), .bus_idle_sleep_factor_in(fac[4]),
        .setup_end_factor_in(fac[8]), .write_status_stage_factor_in(fac[3]), .read_status_stage_factor_in(fac[2]),
        .control_done_factor_in(fac[1]), .control_sequence_fault_factor_in(fac[0]),
        .supply_change_flag_in(flg[4]), .wakeup_flag_in(flg[3]), .frame_start_flag_in(flg[2]),
        .device_state_changed_flag_in(flg[1]), .control_stage_changed_flag_in(flg[0]),
        .ep_drained_flag_in(drn), .ep_unready_flag_in(unr), .ep_available_flag_in(avl),
        .device_state_flag_set_out(st_set), .control_stage_flag_set_out(cs_set),
        .wakeup_irq_en_out(wk_en), .irq_out(irq));

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
        u_cpu.read(a, v);
        check(v, exp);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog for a hung run
    initial
    begin
        #100us;
        err_total++;
        test_done();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        tick(20);
        rst_n_in = 1'b1;
        tick(3);
        for (int i = 0; i < 4; i++)
            rd_check(regs[i], 16'h0000);
        rd_check(8'h18, 16'h0000);
        u_cpu.write(8'h10, 16'ha5c3);
        rd_check(8'h10, 16'ha5c3);
        for (int i = 1; i < 4; i++)
        begin
            u_cpu.write(regs[i], 16'h003f);
            rd_check(regs[i], 16'h003f);
        end
        for (int i = 0; i < 8; i++)
        begin
            u_cpu.write(8'h10, 16'h0001 << i);
            for (int f = 0; f < 9; f++)
            begin
                fac = 9'h001 << f;
                tick(1);
                fac = 9'h000;
                check({14'h0, st_set, cs_set}, {14'h0, f == i && i >= 4, f == 8 || (f == i && i < 4)});
            end
        end
        rd_check(8'h10, 16'h0080);
        for (int s = 0; s < 8; s++)
        begin
            u_cpu.write(8'h10, 16'h0100 << s);
            {flg, drn[5], unr[5], avl[5]} = 8'hff & ~(8'h01 << s);
            tick(2);
            check({15'h0, irq}, 16'h0000);
            check({15'h0, wk_en}, {15'h0, s == 6});
            {flg, drn[5], unr[5], avl[5]} = 8'hff;
            tick(2);
            check({15'h0, irq}, 16'h0001);
        end
        {flg, drn[5], unr[5], avl[5]} = 8'h04;
        u_cpu.write(8'h16, 16'h001f);
        u_cpu.write(8'h10, 16'h0400);
        tick(1);
        check({15'h0, irq}, 16'h0000);
        drn = 6'h01;
        tick(2);
        check({15'h0, irq}, 16'h0001);
        drn = 6'h00;
        tick(2);
        check({15'h0, irq}, 16'h0000);
        soft_rst = 1'b1;
        tick(1);
        soft_rst = 1'b0;
        for (int i = 0; i < 4; i++)
            rd_check(regs[i], 16'h0000);
        test_done();
    end
endmodule

bind usbie_top usbie_monitor #(.NUM_EP(NUM_EP)) u_mon (.ref_clk_in, .rst_n_in, .soft_rst_in, .cpu_cs_n_in,
    .cpu_rd_n_in, .cpu_wr_n_in, .cpu_addr_in, .cpu_data_in, .cpu_data_out, .cpu_data_oe_n_out,
    .bus_reset_factor_in, .address_set_factor_in, .configuration_set_factor_in, .bus_idle_sleep_factor_in,
    .setup_end_factor_in, .write_status_stage_factor_in, .read_status_stage_factor_in, .control_done_factor_in,
    .control_sequence_fault_factor_in, .supply_change_flag_in, .wakeup_flag_in, .frame_start_flag_in,
    .device_state_changed_flag_in, .control_stage_changed_flag_in, .ep_drained_flag_in, .ep_unready_flag_in,
    .ep_available_flag_in, .device_state_flag_set_out, .control_stage_flag_set_out, .wakeup_irq_en_out, .irq_out);
`default_nettype wire
